// [hw/uart_isr_lcr_pkg.sv]
// Shared constants and types for the interrupt identification and line format block.
// Assumes one core clock and a synchronous active-high reset in every clocked user.
package uart_isr_lcr_pkg;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_IDENT = 3'h2;
  localparam logic [2:0] OFF_FORMAT = 3'h3;
  localparam logic [7:0] IDENT_RESET = 8'h01;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************************************
  // Identification codes, low six bits, and FIFO indication, top two bits
  // ****************************************************************
  localparam logic [5:0] ID_LINE = 6'h06;
  localparam logic [5:0] ID_RXDATA = 6'h04;
  localparam logic [5:0] ID_TIMEOUT = 6'h0c;
  localparam logic [5:0] ID_THR = 6'h02;
  localparam logic [5:0] ID_MODEM = 6'h00;
  localparam logic [5:0] ID_XOFF = 6'h10;
  localparam logic [5:0] ID_FLOW = 6'h20;
  localparam logic [5:0] ID_NONE = 6'h01;
  localparam logic [1:0] FIFO_ON = 2'h3;
  localparam logic [1:0] FIFO_OFF = 2'h0;

  // ****************************************************************
  // Character format
  // ****************************************************************
  localparam logic [3:0] WLEN_BASE = 4'h5;
  localparam logic [2:0] STOP_ONE_HALVES = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF_HALVES = 3'h3;
  localparam logic [2:0] STOP_TWO_HALVES = 3'h4;
  localparam logic [1:0] WLEN_5 = 2'h0;
  localparam int DATA_W = 8;

  // Line format control register layout, bit 7 first
  typedef struct packed {
    logic bank_sel;
    logic brk;
    logic force_par;
    logic even_par;
    logic par_en;
    logic stop_long;
    logic [1:0] wlen;
  } line_format_t;

  // Pending sources offered by the surrounding channel logic
  typedef struct packed {
    logic line_status;
    logic rx_avail;
    logic rx_timeout;
    logic thr_empty;
    logic modem_status;
    logic xoff_seen;
    logic flow_change;
  } irq_src_t;

  // Reported source
  typedef enum logic [2:0] {
    LVL_NONE, LVL_LINE, LVL_RXDATA, LVL_TIMEOUT, LVL_THR, LVL_MODEM, LVL_XOFF, LVL_FLOW
  } irq_level_t;

endpackage : uart_isr_lcr_pkg

// [hw/format_decode.sv]
// Decodes the character size and stop length from the line format register.
// Assumes the caller registers the results if it needs them stable.
`timescale 1ns/1ns
`default_nettype none
module format_decode (
  // Format in
  input wire uart_isr_lcr_pkg::line_format_t fmt,
  // Decoded fields
  output logic [3:0] data_bits,
  output logic [2:0] stop_halves
);

  // Word length 5 to 8 bits
  assign data_bits = uart_isr_lcr_pkg::WLEN_BASE + {2'h0, fmt.wlen}; // RULE19 RULE21

  // Stop length in half bit times
  always_comb begin
    if (!fmt.stop_long) begin
      stop_halves = uart_isr_lcr_pkg::STOP_ONE_HALVES; // RULE20
    end else if (fmt.wlen == uart_isr_lcr_pkg::WLEN_5) begin
      stop_halves = uart_isr_lcr_pkg::STOP_ONE_HALF_HALVES; // RULE18
    end else begin
      stop_halves = uart_isr_lcr_pkg::STOP_TWO_HALVES; // RULE20
    end
  end

endmodule : format_decode
`default_nettype wire

// [hw/parity_unit.sv]
// Computes the parity bit for one character under the programmed format.
// Assumes unused high data bits may hold anything; they are masked here.
`timescale 1ns/1ns
`default_nettype none
module parity_unit #(
  parameter int W = 8
) (
  // Character and format
  input wire logic [W-1:0] data,
  input wire logic [3:0] data_bits,
  input wire uart_isr_lcr_pkg::line_format_t fmt,
  // Result
  output logic par_bit
);

  logic [W-1:0] mask;
  logic ones_odd;

  // Keep only the bits of the programmed size
  always_comb begin
    mask = '0;
    for (int i = 0; i < W; i++) begin
      mask[i] = (4'(i) < data_bits);
    end
  end

  assign ones_odd = ^(data & mask);

  // Odd, even or forced parity
  always_comb begin
    if (!fmt.par_en) begin
      par_bit = 1'b0;
    end else if (fmt.force_par) begin
      par_bit = ~fmt.even_par; // RULE17
    end else if (fmt.even_par) begin
      par_bit = ones_odd; // RULE16
    end else begin
      par_bit = ~ones_odd; // RULE16
    end
  end

endmodule : parity_unit
`default_nettype wire

// [hw/uart_isr_lcr.sv]
// Interrupt identification and line format control for one UART channel.
// Assumes bus strobes are one-cycle pulses synchronous to core_clk.
//
// How it works
// RULE1: Identification read returns the highest of six pending priority levels.
// RULE2: A read clears only the source it reported; lower ones show next.
// RULE3: No source other than the reported one is acknowledged by a read.
// RULE4: Line status is level one, code with bits two and one.
// RULE5: Received data is level two bit two; timeout adds bit three.
// RULE6: Holding register empty reports bit one; modem status reports zeros.
// RULE7: Xoff or special character is level five, bit four.
// RULE8: Flow control change is level six, bit five.
// RULE9: Levels five and six show only with enhanced features enabled.
// RULE10: Xoff bit stays set until matching Xon is received.
// RULE11: Top two bits follow FIFO enable, zero at reset.
// RULE12: Bit zero low while pending, high when idle and at reset.
// RULE13: Format bit seven steers accesses to divisor and enhanced bank.
// RULE14: Format bit six forces the serial output low for break.
// RULE15: Format bit three enables parity generation and checking.
// RULE16: Format bit four selects even when set, odd when clear.
// RULE17: Forced parity gives one when bit four clear, zero when set.
// RULE18: Stop length depends on bit two together with word length.
// RULE19: Bits one and zero set character size both directions.
// RULE20: One stop bit clear; set gives one and half or two.
// RULE21: Size codes zero to three give five to eight bits.
// RULE22: Pending flags are re-evaluated every clock for the next read.
`timescale 1ns/1ns
`default_nettype none
module uart_isr_lcr (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Host register port
  input wire logic cs,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Channel status
  input wire logic fifo_enabled,
  input wire logic enhanced_en,
  input wire uart_isr_lcr_pkg::irq_src_t src,
  input wire logic xon_received,
  // Transmit datapath
  input wire logic [7:0] tx_char,
  input wire logic tx_serial_in,
  output logic tx_serial_out,
  output logic tx_parity_bit,
  // Receive datapath
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_in,
  input wire logic rx_char_valid,
  output logic rx_parity_err,
  // Format to the shifters
  output uart_isr_lcr_pkg::line_format_t fmt,
  output logic [3:0] data_bits,
  output logic [2:0] stop_halves,
  output logic bank_sel,
  // Interrupt summary
  output logic irq_pending
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  uart_isr_lcr_pkg::line_format_t fmt_q;
  uart_isr_lcr_pkg::irq_level_t level;
  logic [5:0] id_code;
  logic [7:0] ident_word;
  logic line_q;
  logic timeout_q;
  logic thr_q;
  logic modem_q;
  logic xoff_q;
  logic flow_q;
  logic rd_ident;
  logic wr_format;
  logic rd_format;
  logic clr_line;
  logic clr_timeout;
  logic clr_thr;
  logic clr_modem;
  logic clr_flow;
  logic any_pending;
  logic [3:0] bits_dec;
  logic [2:0] stop_dec;
  logic tx_par;
  logic rx_par;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic tx_out_q;
  logic tx_par_q;
  logic rx_err_q;
  logic [3:0] data_bits_q;
  logic [2:0] stop_halves_q;
  logic irq_q;

  // ****************************************************************
  // Access decode
  // ****************************************************************

  // Identification sits in the normal bank only
  assign rd_ident = cs && rd_stb && (addr == uart_isr_lcr_pkg::OFF_IDENT) && !fmt_q.bank_sel; // RULE13
  // Format register is reachable in both banks
  assign rd_format = cs && rd_stb && (addr == uart_isr_lcr_pkg::OFF_FORMAT);
  assign wr_format = cs && wr_stb && (addr == uart_isr_lcr_pkg::OFF_FORMAT);

  // ****************************************************************
  // Line format register
  // ****************************************************************

  // Host writes, reset to all zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fmt_q <= uart_isr_lcr_pkg::line_format_t'(uart_isr_lcr_pkg::FORMAT_RESET); // RULE13 RULE14 RULE18 RULE19
    end else if (wr_format) begin
      fmt_q <= uart_isr_lcr_pkg::line_format_t'(wr_data); // RULE15 RULE16
    end
  end

  // Size and stop decode
  format_decode u_format_decode (
    .fmt(fmt_q),
    .data_bits(bits_dec),
    .stop_halves(stop_dec)
  );

  // Parity generator for the transmitter
  parity_unit #(
    .W(uart_isr_lcr_pkg::DATA_W)
  ) u_tx_parity (
    .data(tx_char),
    .data_bits(bits_dec),
    .fmt(fmt_q),
    .par_bit(tx_par)
  );

  // Expected parity for the receiver
  parity_unit #(
    .W(uart_isr_lcr_pkg::DATA_W)
  ) u_rx_parity (
    .data(rx_char),
    .data_bits(bits_dec),
    .fmt(fmt_q),
    .par_bit(rx_par)
  );

  // ****************************************************************
  // Transmit and receive format outputs
  // ****************************************************************

  // Break holds the line low, otherwise pass the shifter; idle high at reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_out_q <= 1'b1;
    end else if (fmt_q.brk) begin
      tx_out_q <= 1'b0; // RULE14
    end else begin
      tx_out_q <= tx_serial_in;
    end
  end

  // Parity bit for the next transmitted character
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_par_q <= 1'b0;
    end else begin
      tx_par_q <= tx_par; // RULE15
    end
  end

  // Receive check, only when parity is enabled
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_err_q <= 1'b0;
    end else if (rx_char_valid) begin
      rx_err_q <= fmt_q.par_en && (rx_par != rx_parity_in); // RULE15 RULE16 RULE17
    end
  end

  // Registered size and stop length
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_bits_q <= uart_isr_lcr_pkg::WLEN_BASE;
      stop_halves_q <= uart_isr_lcr_pkg::STOP_ONE_HALVES;
    end else begin
      data_bits_q <= bits_dec; // RULE19
      stop_halves_q <= stop_dec; // RULE18
    end
  end

  // ****************************************************************
  // Sticky pending sources
  // ****************************************************************

  // Read clears only the source being reported
  assign clr_line = rd_ident && (level == uart_isr_lcr_pkg::LVL_LINE); // RULE2 RULE3
  assign clr_timeout = rd_ident && (level == uart_isr_lcr_pkg::LVL_TIMEOUT); // RULE2 RULE3
  assign clr_thr = rd_ident && (level == uart_isr_lcr_pkg::LVL_THR); // RULE2 RULE3
  assign clr_modem = rd_ident && (level == uart_isr_lcr_pkg::LVL_MODEM); // RULE2 RULE3
  assign clr_flow = rd_ident && (level == uart_isr_lcr_pkg::LVL_FLOW); // RULE2 RULE3

  // Line status event, new event beats the clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      line_q <= 1'b0;
    end else if (src.line_status) begin
      line_q <= 1'b1; // RULE22
    end else if (clr_line) begin
      line_q <= 1'b0;
    end
  end

  // Receive timeout event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timeout_q <= 1'b0;
    end else if (src.rx_timeout) begin
      timeout_q <= 1'b1; // RULE22
    end else if (clr_timeout) begin
      timeout_q <= 1'b0;
    end
  end

  // Holding register empty event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      thr_q <= 1'b0;
    end else if (src.thr_empty) begin
      thr_q <= 1'b1; // RULE22
    end else if (clr_thr) begin
      thr_q <= 1'b0;
    end
  end

  // Modem status event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      modem_q <= 1'b0;
    end else if (src.modem_status) begin
      modem_q <= 1'b1; // RULE22
    end else if (clr_modem) begin
      modem_q <= 1'b0;
    end
  end

  // Xoff seen, released by Xon only, a read leaves it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xoff_q <= 1'b0;
    end else if (src.xoff_seen) begin
      xoff_q <= 1'b1;
    end else if (xon_received) begin
      xoff_q <= 1'b0; // RULE10
    end
  end

  // Flow control change event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flow_q <= 1'b0;
    end else if (src.flow_change) begin
      flow_q <= 1'b1; // RULE22
    end else if (clr_flow) begin
      flow_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Priority selection
  // ****************************************************************

  // Highest pending level, evaluated every clock
  always_comb begin
    if (line_q) begin
      level = uart_isr_lcr_pkg::LVL_LINE; // RULE1
    end else if (src.rx_avail) begin
      level = uart_isr_lcr_pkg::LVL_RXDATA;
    end else if (timeout_q) begin
      level = uart_isr_lcr_pkg::LVL_TIMEOUT;
    end else if (thr_q) begin
      level = uart_isr_lcr_pkg::LVL_THR;
    end else if (modem_q) begin
      level = uart_isr_lcr_pkg::LVL_MODEM;
    end else if (enhanced_en && xoff_q) begin
      level = uart_isr_lcr_pkg::LVL_XOFF; // RULE9
    end else if (enhanced_en && flow_q) begin
      level = uart_isr_lcr_pkg::LVL_FLOW; // RULE9
    end else begin
      level = uart_isr_lcr_pkg::LVL_NONE;
    end
  end

  // Code of the selected level
  always_comb begin
    case (level)
      uart_isr_lcr_pkg::LVL_LINE: id_code = uart_isr_lcr_pkg::ID_LINE; // RULE4
      uart_isr_lcr_pkg::LVL_RXDATA: id_code = uart_isr_lcr_pkg::ID_RXDATA; // RULE5
      uart_isr_lcr_pkg::LVL_TIMEOUT: id_code = uart_isr_lcr_pkg::ID_TIMEOUT; // RULE5
      uart_isr_lcr_pkg::LVL_THR: id_code = uart_isr_lcr_pkg::ID_THR; // RULE6
      uart_isr_lcr_pkg::LVL_MODEM: id_code = uart_isr_lcr_pkg::ID_MODEM; // RULE6
      uart_isr_lcr_pkg::LVL_XOFF: id_code = uart_isr_lcr_pkg::ID_XOFF; // RULE7
      uart_isr_lcr_pkg::LVL_FLOW: id_code = uart_isr_lcr_pkg::ID_FLOW; // RULE8
      default: id_code = uart_isr_lcr_pkg::ID_NONE; // RULE12
    endcase
  end

  assign any_pending = (level != uart_isr_lcr_pkg::LVL_NONE); // RULE12

  // Full identification word with FIFO indication
  assign ident_word = {(fifo_enabled ? uart_isr_lcr_pkg::FIFO_ON : uart_isr_lcr_pkg::FIFO_OFF), id_code}; // RULE11

  // ****************************************************************
  // Read data and outputs
  // ****************************************************************

  // Read capture, unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data_q <= uart_isr_lcr_pkg::IDENT_RESET; // RULE11 RULE12
    end else if (rd_ident) begin
      rd_data_q <= ident_word; // RULE1
    end else if (rd_format) begin
      rd_data_q <= fmt_q;
    end else if (cs && rd_stb) begin
      rd_data_q <= uart_isr_lcr_pkg::READ_ZERO;
    end
  end

  // Read answer marker
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= cs && rd_stb;
    end
  end

  // Interrupt summary
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= any_pending; // RULE22
    end
  end

  // Output wiring
  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign tx_serial_out = tx_out_q;
  assign tx_parity_bit = tx_par_q;
  assign rx_parity_err = rx_err_q;
  assign fmt = fmt_q;
  assign data_bits = data_bits_q;
  assign stop_halves = stop_halves_q;
  assign bank_sel = fmt_q.bank_sel; // RULE13
  assign irq_pending = irq_q;

endmodule : uart_isr_lcr
`default_nettype wire

// [dv/uart_isr_lcr_props.sv]
// Port checks for the interrupt identification and line format block.
// Assumes one core clock and a synchronous active-high srst.
`timescale 1ns/1ns
`default_nettype none
module uart_isr_lcr_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic cs,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // Status and datapath
  input wire logic fifo_enabled,
  input wire logic tx_serial_in,
  input wire logic tx_serial_out,
  input wire uart_isr_lcr_pkg::line_format_t fmt,
  input wire logic [3:0] data_bits,
  input wire logic [2:0] stop_halves,
  input wire logic bank_sel,
  input wire logic irq_pending
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  // Identification read and format write requests
  sequence s_ident_read;
    cs && rd_stb && addr == uart_isr_lcr_pkg::OFF_IDENT && !bank_sel;
  endsequence
  sequence s_format_write;
    cs && wr_stb && addr == uart_isr_lcr_pkg::OFF_FORMAT;
  endsequence
  // Identification read while the divisor bank is selected
  sequence s_ident_hidden;
    cs && rd_stb && addr == uart_isr_lcr_pkg::OFF_IDENT && bank_sel;
  endsequence

  // Bus answers
  a_read_valid_pulse: assert property (rd_valid == $past(cs && rd_stb))
    else $error("read valid does not follow read strobe");
  a_rdata_holds: assert property (!rd_valid && !$past(srst) |-> $stable(rd_data))
    else $error("read data moved without a read");
  a_format_write: assert property (s_format_write |=> fmt == $past(wr_data))
    else $error("format register missed a write");
  a_bank_hides_ident: assert property (s_ident_hidden |=> rd_data == uart_isr_lcr_pkg::READ_ZERO)
    else $error("ident visible while other bank selected");
  a_idle_bit: assert property (s_ident_read |=> rd_data[0] == !irq_pending)
    else $error("idle bit disagrees with pending flag");
  a_fifo_bits: assert property (s_ident_read |=> rd_data[7:6] == ($past(fifo_enabled) ? 2'h3 : 2'h0))
    else $error("top ident bits wrong");

  // Line output and decoded format
  a_break_low: assert property (fmt.brk && $past(fmt.brk) |-> !tx_serial_out)
    else $error("break not holding line low");
  a_serial_copy: assert property (!fmt.brk && !$past(fmt.brk) && !$past(srst)
    |-> tx_serial_out == $past(tx_serial_in))
    else $error("serial output not a copy");
  a_size_decode: assert property (!$past(srst)
    |-> data_bits == uart_isr_lcr_pkg::WLEN_BASE + $past(fmt.wlen))
    else $error("character size decode wrong");
  a_stop_decode: assert property (!$past(srst) |-> stop_halves == ($past(fmt.stop_long)
    ? ($past(fmt.wlen) == uart_isr_lcr_pkg::WLEN_5 ? 3'h3 : 3'h4) : 3'h2))
    else $error("stop length decode wrong");
endmodule : uart_isr_lcr_props

bind uart_isr_lcr uart_isr_lcr_props i_props (.core_clk, .srst, .cs, .rd_stb, .wr_stb, .addr, .wr_data,
  .rd_data, .rd_valid, .fifo_enabled, .tx_serial_in, .tx_serial_out, .fmt, .data_bits, .stop_halves,
  .bank_sel, .irq_pending);
`default_nettype wire

// [dv/uart_host_model.sv]
// Host processor model for the register port.
// Assumes the answer to a read arrives on the edge after the strobe.
`timescale 1ns/1ns
`default_nettype none
module uart_host_model (
  // Clock and answer
  input wire logic core_clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // Request
  output logic cs,
  output logic rd_stb,
  output logic wr_stb,
  output logic [2:0] addr,
  output logic [7:0] wr_data
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle bus at start
  initial begin
    cs = 1'h0;
    rd_stb = 1'h0;
    wr_stb = 1'h0;
    addr = 3'h0;
    wr_data = 8'h00;
  end

  // One strobe cycle after a short random gap of one to three clocks
  task automatic access(input logic rd, input logic [2:0] a, input logic [7:0] wd, output logic [7:0] rdd);
    repeat ($urandom_range(1, 3)) @(posedge core_clk);
    #1;
    cs = 1'h1;
    rd_stb = rd;
    wr_stb = !rd;
    addr = a;
    wr_data = wd;
    @(posedge core_clk);
    #1;
    cs = 1'h0;
    rd_stb = 1'h0;
    wr_stb = 1'h0;
    addr = 3'($urandom);
    wr_data = 8'($urandom);
    rdd = rd_valid === 1'h1 ? rd_data : 8'hxx;
  endtask : access
endmodule : uart_host_model
`default_nettype wire

// [dv/uart_interrupt_status_line_control_test.sv]
// Self-checking bench for the interrupt identification and format block.
// Assumes the host model drives the register port; the bench drives the rest.
`timescale 1ns/1ns
`default_nettype none
module uart_interrupt_status_line_control_test;
  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  logic cs, rd_stb, wr_stb, rd_valid;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data;
  logic fifo_enabled = 1'h0;
  logic enhanced_en = 1'h0;
  logic xon_received = 1'h0;
  logic tx_serial_in = 1'h1;
  logic rx_parity_in = 1'h0;
  logic rx_char_valid = 1'h0;
  logic [7:0] tx_char = 8'h00;
  logic [7:0] rx_char = 8'h00;
  uart_isr_lcr_pkg::irq_src_t src = 7'h00;
  uart_isr_lcr_pkg::line_format_t fmt;
  logic tx_serial_out, tx_parity_bit, rx_parity_err, bank_sel, irq_pending;
  logic [3:0] data_bits;
  logic [2:0] stop_halves;
  int n_mismatch = 0;
  int n_checks = 0;
  int idx;
  logic [6:0] m = 7'h00;
  logic rxav = 1'h0;
  logic [31:0] v;
  logic [7:0] d, e;

  // Clock
  always #10 core_clk = ~core_clk;

  // Design and host
  uart_isr_lcr i_dut (.core_clk, .srst, .cs, .rd_stb, .wr_stb, .addr, .wr_data, .rd_data, .rd_valid,
    .fifo_enabled, .enhanced_en, .src, .xon_received, .tx_char, .tx_serial_in, .tx_serial_out,
    .tx_parity_bit, .rx_char, .rx_parity_in, .rx_char_valid, .rx_parity_err, .fmt, .data_bits,
    .stop_halves, .bank_sel, .irq_pending);
  uart_host_model i_host (.core_clk, .rd_data, .rd_valid, .cs, .rd_stb, .wr_stb, .addr, .wr_data);

  // Expected identification, highest pending first
  function automatic logic [7:0] exp_id();
    logic [5:0] code [7] = '{6'h20, 6'h10, 6'h00, 6'h02, 6'h0c, 6'h04, 6'h06};
    idx = -1;
    for (int i = 6; i >= 0; i--) begin
      if (idx < 0 && (i == 5 ? rxav : m[i]) && (i > 1 || enhanced_en)) idx = i;
    end
    return {fifo_enabled ? 2'h3 : 2'h0, idx < 0 ? 6'h01 : code[idx]};
  endfunction : exp_id

  // Expected parity bit of a character
  function automatic logic par(logic [7:0] c, logic [7:0] f);
    logic [7:0] mk = c & (8'hff >> (2'h3 - f[1:0]));
    return f[5] ? !f[4] : (^mk) ^ !f[4];
  endfunction : par

  // Comparison and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h7831b3c2));
    repeat (3) @(posedge core_clk);
    #1 srst = 1'h0;
    i_host.access(1'h1, 3'h2, 8'h00, d);
    check(d, 8'h01);
    i_host.access(1'h1, 3'h3, 8'h00, d);
    check(d, 8'h00);
    i_host.access(1'h1, 3'h7, 8'h00, d);
    check(d, 8'h00);
    // Random formats: decode, parity, break, bank steering
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      i_host.access(1'h0, 3'h2, v[15:8], d);
      i_host.access(1'h0, 3'h3, v[7:0], d);
      tx_char = v[23:16];
      tx_serial_in = v[24];
      rx_char = v[15:8];
      rx_parity_in = v[25];
      repeat (2) @(posedge core_clk);
      #1 rx_char_valid = 1'h1;
      @(posedge core_clk);
      #1 rx_char_valid = 1'h0;
      check(fmt, v[7:0]);
      check(8'(bank_sel), 8'(v[7]));
      check(8'(data_bits), 8'(4'h5 + v[1:0]));
      check(8'(stop_halves), v[2] ? (v[1:0] == 2'h0 ? 8'h3 : 8'h4) : 8'h2);
      check(8'(tx_serial_out), v[6] ? 8'h00 : 8'(tx_serial_in));
      if (v[3]) check(8'(tx_parity_bit), 8'(par(tx_char, v[7:0])));
      check(8'(rx_parity_err), 8'(v[3] && rx_parity_in !== par(rx_char, v[7:0])));
      i_host.access(1'h1, 3'h3, 8'h00, d);
      check(d, v[7:0]);
      e = v[7] ? 8'h00 : exp_id();
      i_host.access(1'h1, 3'h2, 8'h00, d);
      check(d, e);
    end
    i_host.access(1'h0, 3'h3, 8'h00, d);
    // Pending sources drained one read at a time
    for (int i = 0; i < 6; i++) begin
      v = i == 0 ? 32'h37f : $urandom;
      @(posedge core_clk);
      #1 src = v[6:0];
      fifo_enabled = v[8];
      m = m | (v[6:0] & 7'h5f);
      rxav = v[5];
      @(posedge core_clk);
      #1 src = {1'h0, rxav, 5'h00};
      for (int k = 0; k < 9; k++) begin
        enhanced_en = k[0] ^ v[9];
        e = exp_id();
        i_host.access(1'h1, 3'h2, 8'h00, d);
        check(d, e);
        check(8'(irq_pending), 8'(!e[0]));
        if (idx == 5) begin
          rxav = 1'h0;
          src = 7'h00;
        end else if (idx == 1) begin
          // Xoff survives its own read until Xon arrives
          i_host.access(1'h1, 3'h2, 8'h00, d);
          check(d, e);
          xon_received = 1'h1;
          @(posedge core_clk);
          #1 xon_received = 1'h0;
          m[1] = 1'h0;
        end else if (idx >= 0) begin
          m[idx] = 1'h0;
        end
      end
    end
    give_verdict();
  end
endmodule : uart_interrupt_status_line_control_test
`default_nettype wire
